//--- fswp_map.vh
`ifndef FSWP_MAP_VH
`define FSWP_MAP_VH

// Status register bit positions
`define FSWP_BIT_BUSY 0
`define FSWP_BIT_WEL 1
`define FSWP_BIT_BP_LO 2
`define FSWP_BIT_BP_HI 5
`define FSWP_BIT_QE 6
`define FSWP_BIT_REGISTER_WRITE_DISABLE 7
`define FSWP_STATUS_RST 8'h00
`define FSWP_NV_RST 6'h00

// Instruction codes
`define FSWP_OP_WRITE_ENABLE_CMD 8'h06
`define FSWP_OP_WRITE_DISABLE_CMD 8'h04
`define FSWP_OP_STATUS_READ_CMD 8'h05
`define FSWP_OP_STATUS_WRITE_CMD 8'h01
`define FSWP_OP_FUNCTION_REG_WRITE_CMD 8'h42
`define FSWP_OP_IRP 8'h62
`define FSWP_OP_PP 8'h02
`define FSWP_OP_PPQ_A 8'h32
`define FSWP_OP_PPQ_B 8'h38
`define FSWP_OP_SER_A 8'hd7
`define FSWP_OP_SER_B 8'h20
`define FSWP_OP_HALF_BLOCK_ERASE_CMD 8'h52
`define FSWP_OP_FULL_BLOCK_ERASE_CMD 8'hd8
`define FSWP_OP_CER_A 8'hc7
`define FSWP_OP_CER_B 8'h60

// Density codes
`define FSWP_DEN_512K 2'h0
`define FSWP_DEN_1M 2'h1
`define FSWP_DEN_2M 2'h2
`define FSWP_DEN_4M 2'h3

// Block protection codes
`define FSWP_BP_NONE 4'h0
`define FSWP_BP_TOP1 4'h1
`define FSWP_BP_TOP2 4'h2
`define FSWP_BP_TOP4 4'h3
`define FSWP_BP_ALL 4'h8
`define FSWP_BP_BOT4 4'hc
`define FSWP_BP_BOT2 4'hd
`define FSWP_BP_BOT1 4'he

// Internal write cycle lengths, in sys_clk cycles
`define FSWP_CYC_REG 16'h0028
`define FSWP_CYC_PROG 16'h00c8
`define FSWP_CYC_ERASE 16'h0320

// Synchroniser reset levels {io3, io2, si, cs_n, sck}
`define FSWP_SYNC_RST 5'h1e

`endif

//--- fswp_status_protect.v
`timescale 1ns/100ps
`include "fswp_map.vh"

module fswp_status_protect #(
  parameter [1:0] DENSITY = `FSWP_DEN_4M
) (
  input wire sys_clk,
  input wire rst_n,
  input wire spi_sck,
  input wire spi_cs_n,
  input wire spi_si,
  output wire spi_so,
  output wire spi_so_oe,
  input wire data_line_two_in,
  output wire data_line_two_out,
  output wire data_line_two_oe,
  input wire data_line_three_in,
  output wire data_line_three_out,
  output wire data_line_three_oe,
  output wire [7:0] status_value,
  output wire busy_flag,
  output wire write_enable_latch,
  output wire quad_enable,
  output wire pause_active,
  output wire op_start,
  output wire [7:0] op_code,
  output wire [23:0] op_addr
);

  wire [4:0] raw_in;
  reg [4:0] s1_r;
  reg [4:0] s2_r;
  reg [4:0] s3_r;
  reg [4:0] flt_r;
  reg [4:0] flt_d_r;
  localparam [4:0] SYNC_INIT = `FSWP_SYNC_RST;

  assign raw_in = {data_line_three_in, data_line_two_in, spi_si,
                   spi_cs_n, spi_sck};

  genvar gi;
  generate
    for (gi = 0; gi < 5; gi = gi + 1) begin : g_sync
      always @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_r[gi] <= SYNC_INIT[gi];
          s2_r[gi] <= SYNC_INIT[gi];
          s3_r[gi] <= SYNC_INIT[gi];
          flt_r[gi] <= SYNC_INIT[gi];
          flt_d_r[gi] <= SYNC_INIT[gi];
        end else begin
          s1_r[gi] <= raw_in[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
          if (s2_r[gi] == s3_r[gi]) begin
            flt_r[gi] <= s3_r[gi];
          end
          flt_d_r[gi] <= flt_r[gi];
        end
      end
    end
  endgenerate

  reg busy_r;
  reg wel_r;
  reg [5:0] nv_r;
  reg [15:0] busy_cnt_r;
  reg [7:0] sh_r;
  reg [2:0] bit_cnt_r;
  reg [2:0] byte_cnt_r;
  reg [7:0] op_r;
  reg [23:0] addr_r;
  reg [7:0] data_r;
  reg rd_mode_r;
  reg [7:0] snap_r;
  reg so_r;
  reg start_r;
  reg [7:0] start_op_r;
  reg [23:0] start_addr_r;

  wire qe;
  wire wp_level;
  wire pause_n;
  wire paused;
  wire cs_low;
  wire active;
  wire sck_rise;
  wire sck_fall;
  wire cs_fall;
  wire cs_rise;
  wire [3:0] bp;
  wire [7:0] stat;
  wire [7:0] new_byte;
  wire [2:0] blk;

  assign qe = nv_r[`FSWP_BIT_QE - 2];
  assign bp = nv_r[3:0];
  // Quad mode takes the pin functions away: protect pin reads high
  assign wp_level = qe ? 1'b1 : flt_r[3];
  assign pause_n = qe ? 1'b1 : flt_r[4];
  assign cs_low = ~flt_r[1];
  assign paused = cs_low & ~pause_n;
  assign active = cs_low & ~paused;
  assign sck_rise = flt_r[0] & ~flt_d_r[0];
  assign sck_fall = ~flt_r[0] & flt_d_r[0];
  assign cs_fall = ~flt_r[1] & flt_d_r[1];
  assign cs_rise = flt_r[1] & ~flt_d_r[1];
  assign stat = {nv_r, wel_r, busy_r};
  assign new_byte = {sh_r[6:0], flt_r[2]};

  function [2:0] blk_of;
    input [23:0] a;
    begin
      case (DENSITY)
        `FSWP_DEN_4M: blk_of = a[18:16];
        `FSWP_DEN_2M: blk_of = {1'b0, a[17:16]};
        `FSWP_DEN_1M: blk_of = {2'b00, a[16]};
        default: blk_of = 3'h0;
      endcase
    end
  endfunction

  function prot_hit;
    input [3:0] code;
    input [2:0] b;
    begin
      prot_hit = 1'b0;
      case (code)
        `FSWP_BP_TOP1: begin
          case (DENSITY)
            `FSWP_DEN_4M: prot_hit = (b == 3'h7);
            `FSWP_DEN_2M: prot_hit = (b == 3'h3);
            `FSWP_DEN_1M: prot_hit = (b == 3'h1);
            default: prot_hit = 1'b0;
          endcase
        end
        `FSWP_BP_TOP2: begin
          case (DENSITY)
            `FSWP_DEN_4M: prot_hit = (b >= 3'h6);
            `FSWP_DEN_2M: prot_hit = (b >= 3'h2);
            default: prot_hit = 1'b0;
          endcase
        end
        `FSWP_BP_TOP4: prot_hit = (DENSITY == `FSWP_DEN_4M) && (b >= 3'h4);
        `FSWP_BP_ALL: prot_hit = 1'b1;
        `FSWP_BP_BOT4: prot_hit = (DENSITY == `FSWP_DEN_4M) && (b <= 3'h3);
        `FSWP_BP_BOT2: prot_hit = ((DENSITY == `FSWP_DEN_4M) ||
          (DENSITY == `FSWP_DEN_2M)) && (b <= 3'h1);
        `FSWP_BP_BOT1: prot_hit = (DENSITY != `FSWP_DEN_512K) && (b == 3'h0);
        default: prot_hit = 1'b0;
      endcase
    end
  endfunction

  assign blk = blk_of(addr_r);

  // Command decision at chip-select release, whole bytes only
  reg go_write_enable_cmd;
  reg go_write_disable_cmd;
  reg go_start;
  reg go_nv;
  reg [15:0] go_cyc;
  reg complete;
  reg guarded_ok;

  always @* begin
    go_write_enable_cmd = 1'b0;
    go_write_disable_cmd = 1'b0;
    go_start = 1'b0;
    go_nv = 1'b0;
    go_cyc = `FSWP_CYC_REG;
    complete = cs_rise && (bit_cnt_r == 3'h0) && (byte_cnt_r != 3'h0);
    guarded_ok = complete && wel_r && !busy_r;
    if (complete) begin
      case (op_r)
        `FSWP_OP_WRITE_ENABLE_CMD: go_write_enable_cmd = 1'b1;
        `FSWP_OP_WRITE_DISABLE_CMD: go_write_disable_cmd = 1'b1;
        `FSWP_OP_STATUS_WRITE_CMD: begin
          // Lock bit and low protect pin freeze the register
          if (guarded_ok && byte_cnt_r >= 3'h2 &&
              !(nv_r[5] && !wp_level)) begin
            go_nv = 1'b1;
            go_start = 1'b1;
          end
        end
        `FSWP_OP_FUNCTION_REG_WRITE_CMD: go_start = guarded_ok &&
          (byte_cnt_r >= 3'h2);
        `FSWP_OP_IRP: begin
          go_start = guarded_ok && (byte_cnt_r == 3'h4);
          go_cyc = `FSWP_CYC_PROG;
        end
        `FSWP_OP_PP, `FSWP_OP_PPQ_A, `FSWP_OP_PPQ_B: begin
          go_start = guarded_ok && (byte_cnt_r == 3'h4) &&
                     !prot_hit(bp, blk);
          go_cyc = `FSWP_CYC_PROG;
        end
        `FSWP_OP_SER_A, `FSWP_OP_SER_B, `FSWP_OP_HALF_BLOCK_ERASE_CMD,
        `FSWP_OP_FULL_BLOCK_ERASE_CMD: begin
          go_start = guarded_ok && (byte_cnt_r == 3'h4) &&
                     !prot_hit(bp, blk);
          go_cyc = `FSWP_CYC_ERASE;
        end
        `FSWP_OP_CER_A, `FSWP_OP_CER_B: begin
          go_start = guarded_ok && (bp == 4'h0);
          go_cyc = `FSWP_CYC_ERASE;
        end
        default: go_start = 1'b0;
      endcase
    end
  end

  // Serial shifter and status answer
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_r <= 8'h00;
      bit_cnt_r <= 3'h0;
      byte_cnt_r <= 3'h0;
      op_r <= 8'h00;
      addr_r <= 24'h000000;
      data_r <= 8'h00;
      rd_mode_r <= 1'b0;
      snap_r <= 8'h00;
      so_r <= 1'b0;
    end else begin
      if (cs_fall) begin
        bit_cnt_r <= 3'h0;
        byte_cnt_r <= 3'h0;
        rd_mode_r <= 1'b0;
      end else if (active && sck_rise) begin
        sh_r <= new_byte;
        bit_cnt_r <= bit_cnt_r + 3'h1;
        if (bit_cnt_r == 3'h7) begin
          if (byte_cnt_r == 3'h0) begin
            op_r <= new_byte;
            rd_mode_r <= (new_byte == `FSWP_OP_STATUS_READ_CMD);
          end else if (byte_cnt_r < 3'h4) begin
            addr_r <= {addr_r[15:0], new_byte};
          end
          if (byte_cnt_r == 3'h1) begin
            data_r <= new_byte;
          end
          if (byte_cnt_r != 3'h4) begin
            byte_cnt_r <= byte_cnt_r + 3'h1;
          end
        end
      end
      if (active && sck_fall && rd_mode_r) begin
        // Byte snapshot repeats while the master keeps clocking
        if (bit_cnt_r == 3'h0) begin
          snap_r <= stat;
          so_r <= stat[7];
        end else begin
          so_r <= snap_r[3'h7 - bit_cnt_r];
        end
      end
    end
  end

  // Write cycle engine, latch and protection bits
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      nv_r <= `FSWP_NV_RST;
      busy_cnt_r <= 16'h0000;
      start_r <= 1'b0;
      start_op_r <= 8'h00;
      start_addr_r <= 24'h000000;
    end else begin
      start_r <= go_start;
      if (go_start) begin
        busy_r <= 1'b1;
        busy_cnt_r <= go_cyc;
        start_op_r <= op_r;
        start_addr_r <= addr_r;
      end else if (busy_r) begin
        if (busy_cnt_r == 16'h0001) begin
          busy_r <= 1'b0;
        end
        busy_cnt_r <= busy_cnt_r - 16'h0001;
      end
      if (go_nv) begin
        nv_r <= data_r[7:2];
      end
      // Write-enable in the finishing cycle wins over the clear
      if (go_write_enable_cmd) begin
        wel_r <= 1'b1;
      end else if (go_write_disable_cmd) begin
        wel_r <= 1'b0;
      end else if (busy_r && busy_cnt_r == 16'h0001) begin
        wel_r <= 1'b0;
      end
    end
  end

  assign spi_so = so_r;
  assign spi_so_oe = active & rd_mode_r;
  assign data_line_two_out = 1'b0;
  assign data_line_two_oe = 1'b0;
  assign data_line_three_out = 1'b0;
  assign data_line_three_oe = 1'b0;
  assign status_value = stat;
  assign busy_flag = busy_r;
  assign write_enable_latch = wel_r;
  assign quad_enable = qe;
  assign pause_active = paused;
  assign op_start = start_r;
  assign op_code = start_op_r;
  assign op_addr = start_addr_r;

endmodule

//--- fswp_assertions.sv
`timescale 1ns/100ps
`include "fswp_map.vh"
module fswp_assertions (
  input wire sys_clk,
  input wire rst_n,
  input wire data_line_two_in,
  input wire [7:0] status_value,
  input wire busy_flag,
  input wire write_enable_latch,
  input wire quad_enable,
  input wire pause_active,
  input wire op_start,
  input wire [7:0] op_code
);
  reg [9:0] bcnt_r;
  wire [15:0] blen;
  wire reg_op;
  wire prog_op;
  wire cer_op;
  assign reg_op = op_code == `FSWP_OP_STATUS_WRITE_CMD || op_code == `FSWP_OP_FUNCTION_REG_WRITE_CMD;
  assign prog_op = op_code == `FSWP_OP_PP || op_code == `FSWP_OP_PPQ_A ||
    op_code == `FSWP_OP_PPQ_B || op_code == `FSWP_OP_IRP;
  assign cer_op = op_code == `FSWP_OP_CER_A || op_code == `FSWP_OP_CER_B;
  assign blen = reg_op ? `FSWP_CYC_REG :
    prog_op ? `FSWP_CYC_PROG : `FSWP_CYC_ERASE;
  // Length of the running busy stretch
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n)
      bcnt_r <= 10'h000;
    else if (busy_flag)
      bcnt_r <= bcnt_r + 10'h001;
    else
      bcnt_r <= 10'h000;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence s_begin;
    op_start ##0 $rose(busy_flag);
  endsequence
  sequence s_end;
    $fell(busy_flag);
  endsequence
  property p_map;
    status_value[1:0] == {write_enable_latch, busy_flag} &&
      status_value[6] == quad_enable;
  endproperty
  property p_start;
    op_start |-> $rose(busy_flag);
  endproperty
  property p_hold;
    s_begin |=> busy_flag [*8];
  endproperty
  property p_len;
    s_end |-> bcnt_r == blen[9:0];
  endproperty
  property p_wel_clr;
    s_end |-> !write_enable_latch;
  endproperty
  property p_guard;
    op_start |-> $past(write_enable_latch);
  endproperty
  property p_wel_keep;
    s_begin |-> $stable(write_enable_latch);
  endproperty
  property p_cer;
    op_start && cer_op |-> $past(status_value[5:2]) == 4'h0;
  endproperty
  property p_nv;
    !op_start |-> $stable(status_value[7:2]);
  endproperty
  property p_lock;
    op_start && op_code == `FSWP_OP_STATUS_WRITE_CMD |-> !$past(status_value[7]) ||
      $past(data_line_two_in) || $past(quad_enable);
  endproperty
  property p_quad;
    quad_enable |-> !pause_active;
  endproperty
  a_map: assert property (p_map) else $error("status map");
  a_start: assert property (p_start) else $error("start");
  a_hold: assert property (p_hold) else $error("busy hold");
  a_len: assert property (p_len) else $error("busy len");
  a_wel_clr: assert property (p_wel_clr) else $error("wel");
  a_guard: assert property (p_guard) else $error("guard");
  a_wel_keep: assert property (p_wel_keep) else $error("wk");
  a_cer: assert property (p_cer) else $error("chip erase");
  a_nv: assert property (p_nv) else $error("nv bits");
  a_lock: assert property (p_lock) else $error("lock");
  a_quad: assert property (p_quad) else $error("quad");
endmodule

bind fswp_status_protect fswp_assertions u_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .data_line_two_in(data_line_two_in),
  .status_value(status_value), .busy_flag(busy_flag),
  .write_enable_latch(write_enable_latch), .quad_enable(quad_enable),
  .pause_active(pause_active), .op_start(op_start), .op_code(op_code));

//--- fswp_spi_master.sv
`timescale 1ns/100ps
module fswp_spi_master (
  input wire sys_clk,
  input wire go,
  input wire [2:0] nbytes,
  input wire [31:0] tx,
  input wire so,
  output reg sck,
  output reg cs_n,
  output reg si,
  output reg [7:0] rx,
  output reg done
);
  integer i;
  initial begin
    {sck, si, cs_n, done, rx} = 12'h600;
  end
  always @(posedge go) begin
    @(negedge sys_clk);
    cs_n = 0;
    repeat (4) @(negedge sys_clk);
    for (i = 0; i < nbytes * 8; i = i + 1) begin
      si = tx[31 - i];
      repeat (4) @(negedge sys_clk);
      sck = 1;
      repeat (4) @(negedge sys_clk);
      rx = {rx[6:0], so};
      sck = 0;
    end
    repeat (4) @(negedge sys_clk);
    cs_n = 1;
    si = ~si;
    repeat (8) @(negedge sys_clk);
    done = 1;
    @(negedge sys_clk);
    done = 0;
  end
endmodule

//--- tb.sv
`timescale 1ns/100ps
`include "fswp_map.vh"
module tb;
  localparam [31:0] RD = {`FSWP_OP_STATUS_READ_CMD, 24'h0};
  localparam [31:0] WE = {`FSWP_OP_WRITE_ENABLE_CMD, 24'h0};
  reg sys_clk = 0;
  reg rst_n = 0;
  reg go = 0;
  reg wp = 1;
  reg pz = 1;
  reg rd_chk = 0;
  reg oe_seen = 0;
  reg [2:0] nb = 1;
  reg [31:0] txd = 0;
  reg [31:0] seed = 32'h1ad95bac;
  reg [7:0] d;
  reg [7:0] pmk;
  wire sck, cs_n, si, so, done, op_start, qe, soe;
  wire [7:0] rx, op_code;
  wire [23:0] op_addr;
  integer k, b, k2;
  integer bad_count = 0;
  integer samples_checked = 0;
  logic [7:0] q_st[$];
  logic [7:0] q_op[$];
  logic [23:0] q_ad[$];
  logic [7:0] ops[12] = '{`FSWP_OP_PP, `FSWP_OP_PPQ_A, `FSWP_OP_PPQ_B,
    `FSWP_OP_IRP, `FSWP_OP_STATUS_WRITE_CMD, `FSWP_OP_FUNCTION_REG_WRITE_CMD, `FSWP_OP_SER_A,
    `FSWP_OP_SER_B, `FSWP_OP_HALF_BLOCK_ERASE_CMD, `FSWP_OP_FULL_BLOCK_ERASE_CMD, `FSWP_OP_CER_A,
    `FSWP_OP_CER_B};
  logic [3:0] cds[8] = '{4'h1, 4'h2, 4'h3, 4'h8, 4'hc, 4'hd, 4'he, 4'hf};
  fswp_status_protect #(.DENSITY(`FSWP_DEN_4M)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .spi_sck(sck), .spi_cs_n(cs_n),
    .spi_si(si), .spi_so(so), .spi_so_oe(soe), .data_line_two_in(wp),
    .data_line_two_out(), .data_line_two_oe(), .data_line_three_in(pz),
    .data_line_three_out(), .data_line_three_oe(), .status_value(),
    .busy_flag(), .write_enable_latch(), .quad_enable(qe),
    .pause_active(), .op_start(op_start), .op_code(op_code),
    .op_addr(op_addr));
  fswp_spi_master m (.sys_clk(sys_clk), .go(go), .nbytes(nb), .tx(txd),
    .so(so), .sck(sck), .cs_n(cs_n), .si(si), .rx(rx), .done(done));
  initial forever #12.5 sys_clk = ~sys_clk;
  function [7:0] pm(input [3:0] c);
    case (c)
      4'h1: pm = 8'h80;
      4'h2: pm = 8'hc0;
      4'h3: pm = 8'hf0;
      4'h8: pm = 8'hff;
      4'hc: pm = 8'h0f;
      4'hd: pm = 8'h03;
      4'he: pm = 8'h01;
      default: pm = 8'h00;
    endcase
  endfunction
  task check(input string nm, input logic [31:0] s, input logic [31:0] e);
    begin
      samples_checked++;
      if (s !== e) begin
        bad_count++;
        $display("[FAIL] %s exp %h got %h", nm, e, s);
      end
    end
  endtask
  task give_verdict;
    begin
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  task xfer(input [2:0] n, input [31:0] v);
    begin
      @(negedge sys_clk);
      nb = n;
      txd = v;
      go = 1;
      @(posedge done);
      @(negedge sys_clk);
      go = 0;
    end
  endtask
  task rd(input [7:0] e);
    begin
      q_st.push_back(e);
      oe_seen = 0;
      rd_chk = 1;
      xfer(2, RD);
      rd_chk = 0;
      check("so_oe", oe_seen, 1);
      check("so_oe idle", soe, 0);
    end
  endtask
  task wait_idle;
    begin
      k2 = 0;
      do xfer(2, RD); while (rx[0] !== 1'b0 && ++k2 < 40);
      check("idle", rx[0], 0);
    end
  endtask
  task op(input [7:0] c, input [23:0] a, input acc);
    begin
      xfer(1, WE);
      if (acc) begin
        q_op.push_back(c);
        q_ad.push_back(a);
      end
      xfer(4, {c, a});
      wait_idle;
    end
  endtask
  always @(posedge done) if (rd_chk)
    check("status", rx, q_st.pop_front());
  always @(negedge sys_clk) if (soe === 1'b1) oe_seen = 1;
  always @(negedge sys_clk) if (op_start === 1'b1) begin
    check("op_code", op_code, q_op.pop_front());
    check("op_addr", op_addr, q_ad.pop_front());
  end
  initial begin
    #2400000;
    bad_count++;
    give_verdict;
  end
  initial begin
    repeat (8) @(negedge sys_clk);
    rst_n = 1;
    repeat (2) @(negedge sys_clk);
    rd(8'h00);
    for (k = 0; k < 12; k++)
      xfer(4, {ops[k], 24'h0});
    xfer(1, WE);
    rd(8'h02);
    xfer(1, {`FSWP_OP_WRITE_DISABLE_CMD, 24'h0});
    rd(8'h00);
    for (k = 0; k < 12; k++)
      op(ops[k], 24'h0, 1);
    rd(8'h00);
    xfer(1, WE);
    q_op.push_back(`FSWP_OP_SER_A);
    q_ad.push_back(24'h0);
    xfer(4, {`FSWP_OP_SER_A, 24'h0});
    xfer(4, {`FSWP_OP_PP, 24'h0});
    rd(8'h03);
    wait_idle;
    d = $random(seed) & 8'h3c | 8'h02;
    op(`FSWP_OP_STATUS_WRITE_CMD, {d, 16'h0}, 1);
    rd(d & 8'hfc);
    for (k = 0; k < 8; k++) begin
      pmk = pm(cds[k]);
      op(`FSWP_OP_STATUS_WRITE_CMD, {2'h0, cds[k], 18'h0}, 1);
      for (b = 0; b < 8; b++)
        op(`FSWP_OP_PP, {b[7:0], 16'h0}, !pmk[b]);
      op(`FSWP_OP_CER_A, 24'h0, 0);
    end
    op(`FSWP_OP_STATUS_WRITE_CMD, 24'h800000, 1);
    wp = 0;
    op(`FSWP_OP_STATUS_WRITE_CMD, 24'h0, 0);
    rd(8'h82);
    wp = 1;
    op(`FSWP_OP_STATUS_WRITE_CMD, 24'h0, 1);
    rd(8'h00);
    op(`FSWP_OP_STATUS_WRITE_CMD, 24'h400000, 1);
    pz = 0;
    rd(8'h40);
    check("quad", qe, 1);
    pz = 1;
    op(`FSWP_OP_STATUS_WRITE_CMD, 24'h0, 1);
    check("op queue", q_op.size(), 0);
    give_verdict;
  end
endmodule
